// ==== hdl/cas_pkg.sv ====
// Package for the capacitive-sense auto-scan sequencer.
// Assumes a single 40 MHz system clock domain.
`default_nettype none
package cas_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] OFF_CONFIG = 4'h0;
  localparam logic [3:0] OFF_START = 4'h4;
  localparam logic [3:0] OFF_END = 4'h8;
  localparam logic [3:0] OFF_INSEL = 4'hC;
  localparam logic [4:0] OFF_CTRL = 5'h10;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
  localparam logic [4:0] OFF_PINCFG = 5'h1C;
  // ****************************************
  // Fields
  // ****************************************
  localparam int SOC_LSB = 4;
  localparam logic [2:0] SOC_AUTOSCAN = 3'h7;
  localparam int ACC_LSB = 0;
  localparam int BUSY_BIT = 0;
  localparam int IRQ_PASS = 0;
  localparam int IRQ_GT = 1;
  localparam int IRQ_CONV = 2;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [4:0] INSEL_RST = 5'h1F;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [31:0] PINCFG_RST = 32'h0000_0000;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_WAIT = 2'b10,
    ST_NEXT = 2'b11
  } cas_state_t;
endpackage
`default_nettype wire

// ==== hdl/cas_next_chan.sv ====
// Finds the next analog pin above a channel, else steps up by one.
// Assumes channel indices are 5 bits.
`default_nettype none
module cas_next_chan (
  input wire logic [4:0] cur,
  input wire logic [4:0] start,
  input wire logic [31:0] analog,
  output logic [4:0] nxt
);
  logic [31:0] above;
  logic [4:0] found;
  logic hit;
  genvar g;
  // ****************************************
  // Candidates above current channel
  // ****************************************
  generate
    for (g = 0; g < 32; g++) begin : g_above
      assign above[g] = analog[g] && (5'(g) > cur);
    end
  endgenerate
  always_comb begin
    found = start;
    hit = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (!hit && above[i]) begin
        found = 5'(i);
        hit = 1'b1;
      end
    end
  end
  // Nothing analog above: step by one so end match still occurs
  assign nxt = hit ? found : 5'(cur + 5'h01);
endmodule // cas_next_chan
`default_nettype wire

// ==== hdl/cas_ground_mask.sv ====
// Computes which analog pins in the scan range are grounded.
// Assumes start is not above end.
`default_nettype none
module cas_ground_mask (
  input wire logic [4:0] start,
  input wire logic [4:0] stop,
  input wire logic [4:0] sel,
  input wire logic active,
  input wire logic [31:0] analog,
  output logic [31:0] gnd
);
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_gnd
      assign gnd[g] = active && analog[g] && (5'(g) >= start) && (5'(g) <= stop) && (5'(g) != sel);
    end
  endgenerate
endmodule // cas_ground_mask
`default_nettype wire

// ==== hdl/cas_autoscan.sv ====
// Auto-scan channel sequencer with Avalon-MM register slave.
// Assumes converter handshake and comparator event on sys_clk.
//
// Overview of operation
// R1: Setting the start-of-conversion field to all ones enables auto-scan.
// R2: Firmware loads start and end channels before starting the scan.
// R3: With auto-scan on, writing the start channel also writes the input select.
// R4: With auto-scan on, writing one to the busy bit starts the scan.
// R5: After the accumulation count, the select moves to the next analog pin.
// R6: Other analog pins between start and end are grounded during conversion.
// R7: Advancing repeats until the select equals the end channel.
// R8: After the end channel, the select reloads the start channel and continues.
// R9: A non-analog selected channel still gets one conversion.
// R10: On debug halt the current rotation is finished before stopping.
// R11: Auto-scan keeps running during suspend.
// R12: A greater-than event on a scanned channel wakes the device.
// R13: The input select is written by firmware or by the sequencer.
// R14: End of pass is an equality test of select and end after accumulation.
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`default_nettype none
module cas_autoscan (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  input wire logic debug_halt,
  input wire logic suspend,
  input wire logic conv_done,
  input wire logic gt_event,
  output logic conv_start,
  output logic [4:0] conv_channel,
  output logic [31:0] pin_ground,
  output logic wake,
  output logic irq
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] config_r;
  logic [4:0] start_r;
  logic [4:0] end_r;
  logic [4:0] insel_r;
  logic [4:0] insel_nxt;
  logic [31:0] pincfg_r;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  // Three bits so the largest accumulation of eight can complete
  logic [2:0] acc_cnt_r;
  logic [31:0] gnd_r;
  logic halt_stop_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic err_r;
  logic conv_start_r;
  logic wake_r;
  cas_pkg::cas_state_t state_r;
  cas_pkg::cas_state_t state_nxt;
  // ****************************************
  // Bus decode
  // ****************************************
  // One wait cycle so read data come from a flop
  wire req = (avs_read || avs_write) && !ack_r;
  wire wr = avs_write && ack_r;
  wire [31:0] baddr = {27'h0, avs_address};
  wire hit_cfg = baddr[4:0] == {1'b0, cas_pkg::OFF_CONFIG};
  wire hit_start = baddr[4:0] == {1'b0, cas_pkg::OFF_START};
  wire hit_end = baddr[4:0] == {1'b0, cas_pkg::OFF_END};
  wire hit_insel = baddr[4:0] == {1'b0, cas_pkg::OFF_INSEL};
  wire hit_ctrl = baddr[4:0] == cas_pkg::OFF_CTRL;
  wire hit_stat = baddr[4:0] == cas_pkg::OFF_IRQ_STAT;
  wire hit_mask = baddr[4:0] == cas_pkg::OFF_IRQ_MASK;
  wire hit_pin = baddr[4:0] == cas_pkg::OFF_PINCFG;
  wire hit_any = hit_cfg | hit_start | hit_end | hit_insel | hit_ctrl | hit_stat | hit_mask | hit_pin;
  wire be0 = avs_byteenable[0];
  wire autoscan_en = config_r[cas_pkg::SOC_LSB +: 3] == cas_pkg::SOC_AUTOSCAN; // [R1]
  wire [1:0] acc_sel = config_r[cas_pkg::ACC_LSB +: 2];
  wire [3:0] acc_total = 4'h1 << acc_sel;
  wire busy = state_r != cas_pkg::ST_IDLE;
  wire go = wr && hit_ctrl && be0 && avs_writedata[cas_pkg::BUSY_BIT] && autoscan_en; // [R4]
  wire stop_fw = wr && hit_ctrl && be0 && !avs_writedata[cas_pkg::BUSY_BIT];
  wire sel_analog = pincfg_r[insel_r];
  wire acc_last = !sel_analog || ({1'b0, acc_cnt_r} + 4'h1 >= acc_total); // [R9]
  wire at_end = insel_r == end_r; // [R7] [R14]
  wire in_range = (insel_r >= start_r) && (insel_r <= end_r);
  wire gt_hit = gt_event && busy && in_range;
  wire [4:0] adv_chan;
  wire [31:0] gnd_nxt;
  wire [2:0] ev = {conv_done && busy, gt_hit, conv_done && busy && acc_last && at_end};
  // ****************************************
  // Helpers
  // ****************************************
  cas_next_chan u_next (
    .cur(insel_r),
    .start(start_r),
    .analog(pincfg_r),
    .nxt(adv_chan)
  );
  // Mask built from next state so the registered pins track the select
  cas_ground_mask u_gnd (
    .start(start_r),
    .stop(end_r),
    .sel(insel_nxt),
    .active(state_nxt == cas_pkg::ST_WAIT),
    .analog(pincfg_r),
    .gnd(gnd_nxt)
  ); // [R6]
  // ****************************************
  // Sequencer
  // ****************************************
  // Suspend is deliberately not an input to the state logic
  always_comb begin
    state_nxt = state_r;
    insel_nxt = insel_r;
    if (wr && hit_insel && be0) begin
      insel_nxt = avs_writedata[4:0]; // [R13]
    end
    if (wr && hit_start && be0 && autoscan_en) begin
      insel_nxt = avs_writedata[4:0]; // [R3]
    end
    unique case (state_r)
      cas_pkg::ST_IDLE: begin
        if (go) begin
          state_nxt = cas_pkg::ST_CONV;
        end
      end
      cas_pkg::ST_CONV: begin
        state_nxt = cas_pkg::ST_WAIT;
      end
      cas_pkg::ST_WAIT: begin
        if (conv_done) begin
          state_nxt = acc_last ? cas_pkg::ST_NEXT : cas_pkg::ST_CONV;
        end
      end
      cas_pkg::ST_NEXT: begin
        if (at_end) begin
          insel_nxt = start_r; // [R8]
        end else begin
          insel_nxt = adv_chan; // [R5]
        end
        // Halt or disable only stops at a pass boundary
        if (at_end && (halt_stop_r || !autoscan_en)) begin
          state_nxt = cas_pkg::ST_IDLE; // [R10]
        end else begin
          state_nxt = cas_pkg::ST_CONV; // [R11]
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= cas_pkg::ST_IDLE;
      insel_r <= cas_pkg::INSEL_RST;
      acc_cnt_r <= 3'h0;
      conv_start_r <= 1'b0;
      halt_stop_r <= 1'b0;
      gnd_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      insel_r <= insel_nxt;
      conv_start_r <= state_nxt == cas_pkg::ST_CONV;
      gnd_r <= gnd_nxt; // [R6]
      if (state_r == cas_pkg::ST_NEXT || state_r == cas_pkg::ST_IDLE) begin
        acc_cnt_r <= 3'h0;
      end else if (state_r == cas_pkg::ST_WAIT && conv_done) begin
        acc_cnt_r <= acc_cnt_r + 3'h1;
      end
      if (state_nxt == cas_pkg::ST_IDLE) begin
        halt_stop_r <= 1'b0;
      end else if (debug_halt || stop_fw) begin
        halt_stop_r <= 1'b1;
      end
    end
  end
  // ****************************************
  // Register file and bus answer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      config_r <= cas_pkg::CONFIG_RST;
      start_r <= cas_pkg::CHAN_RST;
      end_r <= cas_pkg::CHAN_RST;
      pincfg_r <= cas_pkg::PINCFG_RST;
      mask_r <= cas_pkg::IRQ_RST;
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
      if (wr && hit_cfg && be0) begin
        config_r <= avs_writedata[7:0];
      end
      if (wr && hit_start && be0) begin
        start_r <= avs_writedata[4:0];
      end
      if (wr && hit_end && be0) begin
        end_r <= avs_writedata[4:0];
      end
      if (wr && hit_mask && be0) begin
        mask_r <= avs_writedata[2:0];
      end
      for (int b = 0; b < 4; b++) begin
        if (wr && hit_pin && avs_byteenable[b]) begin
          pincfg_r[b*8 +: 8] <= avs_writedata[b*8 +: 8];
        end
      end
    end
  end
  // Set wins over write-one-to-clear
  wire [2:0] w1c = (wr && hit_stat && be0) ? avs_writedata[2:0] : 3'h0;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_r <= cas_pkg::IRQ_RST;
      wake_r <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~w1c) | ev;
      wake_r <= gt_hit; // [R12]
    end
  end
  wire [31:0] rmux =
    hit_cfg ? {24'h0, config_r} :
    hit_start ? {27'h0, start_r} :
    hit_end ? {27'h0, end_r} :
    hit_insel ? {27'h0, insel_r} :
    hit_ctrl ? {31'h0, busy} :
    hit_stat ? {29'h0, stat_r} :
    hit_mask ? {29'h0, mask_r} :
    hit_pin ? pincfg_r : 32'h0000_0000;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      rdata_r <= (req && avs_read) ? rmux : 32'h0000_0000;
      err_r <= req && !hit_any;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = rdata_r;
  assign avs_response_err = err_r;
  assign conv_start = conv_start_r;
  assign pin_ground = gnd_r;
  assign conv_channel = insel_r;
  assign wake = wake_r;
  assign irq = |(stat_r & mask_r);
endmodule // cas_autoscan
`default_nettype wire

// ==== verif/cas_conv_model.sv ====
// Converter stand-in: answers each start with one done pulse.
// Assumes conv_start is a one-cycle pulse on sys_clk.
`default_nettype none
module cas_conv_model #(
  parameter int DELAY = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic conv_start,
  output logic conv_done
);
  // ****************
  // Conversion timer
  // ****************
  logic [3:0] cnt_r;
  // Fixed slow answer keeps the grounding check clear of done
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt_r == 4'h1);
      if (conv_start) begin
        cnt_r <= 4'(DELAY);
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule // cas_conv_model
`default_nettype wire

// ==== verif/cas_autoscan_assertions.sv ====
// Port checker for the auto-scan sequencer.
// Assumes one clock domain, sync active-low reset.
`default_nettype none
module cas_autoscan_assertions (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic avs_response_err,
  input wire logic gt_event,
  input wire logic conv_start,
  input wire logic [4:0] conv_channel,
  input wire logic [31:0] pin_ground,
  input wire logic wake
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire req = avs_read | avs_write;
  // ****************
  // Properties
  // ****************
  property p_idle_ready; !req |-> !avs_waitrequest; endproperty
  a_idle_ready: assert property (p_idle_ready) else $error("wait while idle");
  property p_one_wait; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait too long");
  property p_err_ans; avs_response_err |-> req && !avs_waitrequest; endproperty
  a_err_ans: assert property (p_err_ans) else $error("stray error");
  property p_rd_zero; !req |-> avs_readdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data lingers");
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_chan_hold; conv_start |=> $stable(conv_channel) [*2]; endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved");
  property p_gnd_sel; pin_ground[conv_channel] == 1'b0; endproperty
  a_gnd_sel: assert property (p_gnd_sel) else $error("selected pin grounded");
  property p_wake; wake |-> $past(gt_event); endproperty
  a_wake: assert property (p_wake) else $error("wake without event");
  c_end: cover property (conv_start && conv_channel == 5'h05);
  c_wake: cover property (wake);
  c_err: cover property (avs_response_err);
endmodule // cas_autoscan_assertions
bind cas_autoscan cas_autoscan_assertions u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err), .gt_event(gt_event),
  .conv_start(conv_start), .conv_channel(conv_channel), .pin_ground(pin_ground), .wake(wake));
`default_nettype wire

// ==== verif/cas_autoscan_tb_top.sv ====
// Self-checking bench for the auto-scan sequencer.
// Assumes the converter model answers every start.
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module cas_autoscan_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic debug_halt = 1'b0;
  logic suspend = 1'b0;
  logic gt_event = 1'b0;
  wire logic conv_done, conv_start, avs_waitrequest, avs_response_err, wake, irq;
  wire logic [31:0] avs_readdata, pin_ground;
  wire logic [4:0] conv_channel;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] rd;
  logic er;
  always #12.5 sys_clk = ~sys_clk;
  cas_autoscan u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err), .debug_halt(debug_halt),
    .suspend(suspend), .conv_done(conv_done), .gt_event(gt_event), .conv_start(conv_start),
    .conv_channel(conv_channel), .pin_ground(pin_ground), .wake(wake), .irq(irq));
  cas_conv_model u_cnv (.sys_clk(sys_clk), .rst_n(rst_n), .conv_start(conv_start), .conv_done(conv_done));
  // ****************
  // Tasks
  // ****************
  task test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    er = avs_response_err;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin err_total++; test_done(); end
  endtask
  task rd_chk(input string n, input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask
  task wait_cs;
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      if (conv_start === 1'b1) break;
    end
    if (i == 60) begin err_total++; test_done(); end
  endtask
  task t_reset;
    rd_chk("insel", 5'(cas_pkg::OFF_INSEL), 32'h1F);
    rd_chk("config", 5'(cas_pkg::OFF_CONFIG), 32'h0);
    acc(1'b0, 5'h1E, 32'h0);
    `CHK("unmapped", 1'b1, er)
    $display("test reset done");
  endtask
  task t_scan;
    logic [4:0] exp [14] = '{5'h1, 5'h2, 5'h2, 5'h3, 5'h3, 5'h5, 5'h5, 5'h1, 5'h2, 5'h2, 5'h3, 5'h3, 5'h5, 5'h5};
    int k;
    suspend <= 1'b1;
    acc(1'b1, cas_pkg::OFF_PINCFG, 32'h2C);
    acc(1'b1, 5'(cas_pkg::OFF_CONFIG), 32'h71);
    acc(1'b1, 5'(cas_pkg::OFF_START), 32'h1);
    rd_chk("copy", 5'(cas_pkg::OFF_INSEL), 32'h1);
    acc(1'b1, 5'(cas_pkg::OFF_END), 32'h5);
    acc(1'b1, cas_pkg::OFF_CTRL, 32'h1);
    for (k = 0; k < 14; k++) begin
      wait_cs();
      `CHK("chan", exp[k], conv_channel)
      @(posedge sys_clk);
      `CHK("gnd", 32'h2C & ~(32'h1 << exp[k]), pin_ground)
      if (k == 1) begin
        gt_event <= 1'b1;
        @(posedge sys_clk);
        gt_event <= 1'b0;
        @(posedge sys_clk);
        `CHK("wake", 1'b1, wake)
      end
      // Halt lands mid-pass so the rest of the rotation is seen
      if (k == 10) debug_halt <= 1'b1;
    end
    repeat (60) begin
      @(posedge sys_clk);
      `CHK("stopped", 1'b0, conv_start)
    end
    rd_chk("busy", cas_pkg::OFF_CTRL, 32'h0);
    $display("test scan done");
  endtask
  task t_irq;
    `CHK("irq_masked", 1'b0, irq)
    rd_chk("status", cas_pkg::OFF_IRQ_STAT, 32'h7);
    acc(1'b1, cas_pkg::OFF_IRQ_MASK, 32'h1 << cas_pkg::IRQ_PASS);
    @(posedge sys_clk);
    `CHK("irq_on", 1'b1, irq)
    acc(1'b1, cas_pkg::OFF_IRQ_STAT, 32'h1);
    @(posedge sys_clk);
    `CHK("irq_off", 1'b0, irq)
    rd_chk("status_w1c", cas_pkg::OFF_IRQ_STAT, 32'h6);
    $display("test irq done");
  endtask
  task t_accum;
    int k;
    debug_halt <= 1'b0;
    acc(1'b1, 5'(cas_pkg::OFF_CONFIG), 32'h73);
    acc(1'b1, 5'(cas_pkg::OFF_START), 32'h5);
    acc(1'b1, 5'(cas_pkg::OFF_END), 32'h5);
    acc(1'b1, cas_pkg::OFF_IRQ_STAT, 32'h7);
    acc(1'b1, cas_pkg::OFF_CTRL, 32'h1);
    // Largest accumulation: eight conversions before the pass ends
    for (k = 0; k < 8; k++) begin
      wait_cs();
      `CHK("acc_chan", 5'h05, conv_channel)
    end
    rd_chk("acc_open", cas_pkg::OFF_IRQ_STAT, 32'h4);
    wait_cs();
    `CHK("acc_wrap", 5'h05, conv_channel)
    rd_chk("acc_pass", cas_pkg::OFF_IRQ_STAT, 32'h5);
    acc(1'b1, cas_pkg::OFF_CTRL, 32'h0);
    repeat (100) @(posedge sys_clk);
    rd_chk("fw_stop", cas_pkg::OFF_CTRL, 32'h0);
    $display("test accum done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_scan();
    t_irq();
    t_accum();
    test_done();
  end
endmodule // cas_autoscan_tb_top
`default_nettype wire
